// ---- design/req_decoder.sv ----
// Request packet decoder: link sampling, packet assembly, decode, delay
// slots, core command registers, data burst path and APB control registers.
// Assumes the link clock is slow enough (>= 8 system clocks per period)
// to be sampled, and that the controller keeps the command spacing.
`timescale 1ns/1ps
`default_nettype none
`include "req_decoder_cfg.svh"

module req_decoder
  import req_decoder_pkg::*;
#(
  parameter int DW = 16,
  parameter int NW = 16
) (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst,
  // request link
  input  wire logic                      master_clock_pos,
  input  wire logic                      master_clock_neg,
  input  wire logic [11:0]               request_bus,
  // data link
  input  wire logic [DW-1:0]             data_bus_in,
  output logic [DW-1:0]                  data_bus_out,
  output logic                           data_bus_oe,
  // register bus
  input  wire req_decoder_pkg::apb_req_t apb_req,
  output req_decoder_pkg::apb_rsp_t      apb_rsp,
  // memory core
  output req_decoder_pkg::strobe_t       strobes,
  output req_decoder_pkg::row_addr_t     open_addr,
  output logic [2:0]                     close_bank,
  output req_decoder_pkg::col_addr_t     col_addr,
  output logic [2:0]                     rfsh_target_bnk,
  output logic [11:0]                    rfsh_row_ptr,
  output logic [NW*DW-1:0]               wr_packet,
  output logic                           wr_packet_valid,
  input  wire logic [NW*DW-1:0]          rd_packet
);
  import req_decoder_pkg::*;

  typedef struct packed {
    logic [2:0]          ck_p;
    logic [2:0]          ck_n;
    logic [2:0][11:0]    rq;
    logic [2:0][DW-1:0]  dq;
    logic                lvl;
    logic [11:0]         hi;
    logic [23:0]         pkt;
    logic                pkt_v;
    slot_t               q_open;
    slot_t               q_close;
    slot_t               q_col;
    slot_t               q_rfsh;
    strobe_t             stb;
    row_addr_t           oa;
    logic [2:0]          cb;
    col_addr_t           ca;
    logic [2:0]          rb;
    logic [11:0]         ptr;
    logic [7:0]          open_bk;
    logic                pd;
    logic                trim;
    logic                en;
    logic [31:0]         prdata;
    dp_state_t           dp;
    logic [4:0]          beat;
    logic [3:0]          bdiv;
    logic [NW*DW-1:0]    sh;
    logic                wr_v;
    logic [DW-1:0]       dout;
    logic                oe;
  } st_t;

  st_t s;
  st_t next_s;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic slot_t push(slot_t q, cmd_t c, logic [1:0] d);
    push    = q;
    push[d] = c;
  endfunction : push

  function automatic slot_t step(slot_t q);
    step = {cmd_t'('0), q[3:1]};
  endfunction : step

  logic       edge_seen;
  logic       rise;
  logic       fall;
  logic       beat_en;
  logic [3:0] fmt;
  logic       setup_ph;
  logic       wr_acc;
  logic       mapped;
  logic       live;

  assign edge_seen = (s.ck_p[1] == s.ck_p[2]) && (s.ck_p[2] != s.lvl)
                     && (s.ck_n[1] == s.ck_n[2]) && (s.ck_n[2] != s.ck_p[2]);
  assign rise      = edge_seen && s.ck_p[2];
  assign fall      = edge_seen && !s.ck_p[2];
  assign beat_en   = (s.bdiv == 4'h0);
  assign fmt       = s.pkt[`F_FMT +: 4];
  assign setup_ph  = apb_req.psel && !apb_req.penable;
  assign wr_acc    = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign mapped    = (apb_req.paddr == `A_CTRL) || (apb_req.paddr == `A_ROW)
                     || (apb_req.paddr == `A_STAT);
  assign live      = s.pkt_v && s.en && !s.pd;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    cmd_t c;
    c = '0;
    next_s = s;
    next_s.stb   = '0;
    next_s.wr_v  = 1'b0;
    next_s.pkt_v = 1'b0;
    // link inputs: three flops, stages two and three must agree
    next_s.ck_p = {s.ck_p[1:0], master_clock_pos};
    next_s.ck_n = {s.ck_n[1:0], master_clock_neg};
    next_s.rq   = {s.rq[1:0], request_bus};
    next_s.dq   = {s.dq[1:0], data_bus_in};

    if (edge_seen) begin
      next_s.lvl = s.ck_p[2];
    end
    if (rise) begin
      next_s.hi = s.rq[2]; // R01 R03
    end
    if (fall) begin
      next_s.pkt   = {s.hi, s.rq[2]}; // R01 R02
      next_s.pkt_v = 1'b1;
    end

    // open, close, column and refresh command registers change only on a rising link edge
    if (rise) begin
      if (s.q_open[0].v) begin // R07 R09
        next_s.stb.row_open_cmd   = 1'b1;
        next_s.oa                 = '{bank: s.q_open[0].bank,
                                      row: s.q_open[0].row};
        next_s.open_bk[s.q_open[0].bank] = 1'b1;
      end
      if (s.q_close[0].v) begin // R07 R10
        next_s.stb.bank_close_cmd = 1'b1;
        next_s.cb                 = s.q_close[0].bank;
        next_s.open_bk[s.q_close[0].bank] = 1'b0;
      end
      if (s.q_col[0].v) begin // R07
        next_s.ca = '{bank: s.q_col[0].bank, col: s.q_col[0].col,
                      sub: s.q_col[0].sub, mask: s.q_col[0].mask};
        unique case (s.q_col[0].kind)
          3'h0: begin
            next_s.stb.col_read_cmd = 1'b1; // R15
            next_s.dp               = DP_FETCH;
          end
          3'h1: begin
            next_s.stb.col_write_cmd = 1'b1; // R15
            next_s.dp                = DP_WRITE;
            next_s.beat              = 5'h0;
          end
          default: begin
            next_s.stb.masked_store_cmd = 1'b1; // R17
            next_s.dp                   = DP_WRITE;
            next_s.beat                 = 5'h0;
          end
        endcase
      end
      if (s.q_rfsh[0].v) begin // R07 R24
        next_s.rb = s.q_rfsh[0].bank;
        if (s.q_rfsh[0].kind == `RF_CLOSE) begin
          next_s.stb.rfsh_close_cmd = 1'b1;
          next_s.open_bk[s.q_rfsh[0].bank] = 1'b0;
        end else begin
          next_s.stb.rfsh_open_cmd      = 1'b1;
          next_s.stb.rfsh_open_step_cmd = (s.q_rfsh[0].kind == `RF_STEP);
          next_s.open_bk[s.q_rfsh[0].bank] = 1'b1;
        end
      end
      next_s.q_open  = step(s.q_open); // R06
      next_s.q_close = step(s.q_close);
      next_s.q_col   = step(s.q_col);
      next_s.q_rfsh  = step(s.q_rfsh);
    end

    // pointer moves on only after the activate has been presented
    if (s.stb.rfsh_open_step_cmd) begin
      next_s.ptr = s.ptr + 12'h001; // R24
    end

    // ---------------------------------------------------------------
    // register bus
    // ---------------------------------------------------------------
    if (setup_ph) begin
      unique case (apb_req.paddr)
        `A_CTRL: next_s.prdata = {31'h0, s.en};
        `A_ROW:  next_s.prdata = {20'h0, s.ptr}; // R22
        `A_STAT: next_s.prdata = {22'h0, s.trim, s.pd, s.open_bk};
        default: next_s.prdata = 32'h0;
      endcase
    end
    if (wr_acc && apb_req.paddr == `A_CTRL) begin
      next_s.en = apb_req.pwdata[`C_EN]; // R22
      if (apb_req.pwdata[`C_WAKE]) begin
        next_s.pd = 1'b0;
      end
    end
    if (wr_acc && apb_req.paddr == `A_ROW) begin
      next_s.ptr = apb_req.pwdata[11:0]; // R22
    end

    // ---------------------------------------------------------------
    // decode; packet loads win over software writes
    // ---------------------------------------------------------------
    if (live) begin
      if (fmt[3]) begin // R04 R23
        c.v    = 1'b1; // R17
        c.kind = 3'h2;
        c.bank = s.pkt[`F_COL_BNK +: 3]; // R16
        c.col  = s.pkt[`F_COL +: 6];
        c.sub  = s.pkt[`F_SUB +: 4];
        c.mask = s.pkt[`F_MASK +: 8];
        next_s.q_col = push(s.q_col, c, {1'b0, s.pkt[`F_COL_SLIP]}); // R06
      end else if (fmt[3:2] == `FMT_OPEN_TOP) begin
        c.v    = 1'b1; // R14
        c.bank = s.pkt[`F_OPEN_BNK +: 3];
        c.row  = {1'b0, s.pkt[`F_OPEN_ROW +: 11]};
        next_s.q_open = push(s.q_open, c, {1'b0, s.pkt[`F_OPEN_SLIP]});
      end else begin
        unique case (fmt[1:0])
          `FMT_NOP: begin
          end
          `FMT_COL: begin
            c.v    = 1'b1; // R15 R16
            c.kind = {2'b00, s.pkt[`F_DIR]};
            c.bank = s.pkt[`F_COL_BNK +: 3];
            c.col  = s.pkt[`F_COL +: 6];
            c.sub  = s.pkt[`F_SUB +: 4];
            c.mask = 8'hff;
            next_s.q_col = push(s.q_col, c, {1'b0, s.pkt[`F_COL_SLIP]});
          end
          `FMT_EXT: begin
            unique case (s.pkt[`F_MAINT +: 4]) // R21 R26
              `MX_CUR: begin
                next_s.stb.current_trim_cmd = 1'b1;
                next_s.trim                 = 1'b1;
              end
              `MX_IMP: next_s.stb.impedance_trim_cmd = 1'b1;
              `MX_END: begin
                next_s.stb.trim_end_cmd = 1'b1;
                next_s.trim             = 1'b0;
              end
              `MX_PDN: begin
                next_s.stb.powerdown_cmd = 1'b1;
                next_s.pd                = 1'b1;
              end
              default: begin // R27
              end
            endcase
          end
          `FMT_CLOSE: begin // R18
            if (s.pkt[`F_CLOSE_SUB + 2]) begin // R19 R25
              c.v    = 1'b1;
              c.bank = s.pkt[`F_CLOSE_BNK +: 3];
              next_s.q_close = push(s.q_close, c,
                                    s.pkt[`F_CLOSE_SUB +: 2]);
            end
            c = '0;
            unique case (s.pkt[`F_RFSH_SUB +: 3]) // R20 R24
              `RF_CLOSE, `RF_OPEN, `RF_STEP: begin
                c.v    = 1'b1;
                c.kind = s.pkt[`F_RFSH_SUB +: 3];
                c.bank = s.pkt[`F_RFSH_FLD +: 3];
                next_s.q_rfsh = push(s.q_rfsh, c,
                                     s.pkt[`F_RFSH_FLD + 6 +: 2]);
              end
              `RF_LOW: next_s.ptr[7:0]  = s.pkt[`F_RFSH_FLD +: 8];
              `RF_MID: next_s.ptr[11:8] = s.pkt[`F_RFSH_FLD +: 4];
              default: begin // R27
              end
            endcase
          end
        endcase
      end
    end

    // ---------------------------------------------------------------
    // data burst, one word per beat
    // ---------------------------------------------------------------
    next_s.bdiv = beat_en ? 4'(`CLKS_PER_BEAT - 1) : s.bdiv - 4'h1; // R05
    unique case (s.dp)
      DP_IDLE: begin
      end
      DP_FETCH: begin
        next_s.sh   = rd_packet; // R13
        next_s.beat = 5'h0;
        next_s.dp   = DP_READ;
      end
      DP_WRITE: begin
        if (beat_en) begin
          next_s.sh   = {s.dq[2], s.sh[NW*DW-1:DW]}; // R12
          next_s.beat = s.beat + 5'h1;
          if (s.beat == 5'(NW - 1)) begin
            next_s.wr_v = 1'b1;
            next_s.dp   = DP_IDLE;
          end
        end
      end
      DP_READ: begin
        if (beat_en) begin
          if (s.beat == 5'(NW)) begin
            next_s.oe = 1'b0;
            next_s.dp = DP_IDLE;
          end else begin
            next_s.dout = s.sh[DW-1:0]; // R13
            next_s.sh   = s.sh >> DW;
            next_s.oe   = 1'b1;
            next_s.beat = s.beat + 5'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s    <= '0;
      s.dp <= DP_IDLE;
      s.en <= `EN_RST;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign data_bus_out    = s.dout;
  assign data_bus_oe     = s.oe;
  assign strobes         = s.stb;
  assign open_addr       = s.oa;
  assign close_bank      = s.cb;
  assign col_addr        = s.ca;
  assign rfsh_target_bnk = s.rb;
  assign rfsh_row_ptr    = s.ptr;
  assign wr_packet       = s.sh;
  assign wr_packet_valid = s.wr_v;
  assign apb_rsp.prdata  = s.prdata;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !mapped;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb_chk @(posedge clock);
  endclocking
  default disable iff (rst);

  a_packet_join: assert property (fall |=> s.pkt_v // R01
    && s.pkt == {$past(s.hi), $past(s.rq[2])})
    else $error("packet not joined from both words");
  a_core_on_edge: assert property ((s.stb.row_open_cmd // R07
    || s.stb.bank_close_cmd || s.stb.col_read_cmd
    || s.stb.rfsh_open_cmd) |-> $past(rise))
    else $error("core command not on rising link edge");
  a_open_marks: assert property (s.stb.row_open_cmd // R09
    && !s.stb.rfsh_close_cmd |-> s.open_bk[s.oa.bank])
    else $error("opened bank not marked open");
  a_open_prompt: assert property (live && fmt[3:2] == 2'h1 // R06
    && !s.pkt[`F_OPEN_SLIP] |-> ##[1:16] s.stb.row_open_cmd)
    else $error("undelayed open not issued in time");
  a_read_burst: assert property (s.dp == DP_FETCH |=> // R13
    s.dp == DP_READ ##1 s.oe [*8])
    else $error("read burst not driven");
  a_write_done: assert property (s.wr_v |-> // R12
    $past(s.dp) == DP_WRITE && $past(s.beat) == 5'(NW - 1))
    else $error("write packet released early");
  a_ptr_step: assert property (s.stb.rfsh_open_step_cmd && !live // R24
    && !wr_acc |=> s.ptr == $past(s.ptr) + 12'h001)
    else $error("refresh row pointer not stepped");
  a_pdn_enter: assert property (s.stb.powerdown_cmd |-> s.pd // R26
    ##1 (s.pd || $past(wr_acc)))
    else $error("power down state not held");
  a_close_rsvd: assert property (live && fmt == 4'h3 // R27
    && s.pkt[`F_CLOSE_SUB +: 3] inside {3'h1, 3'h2, 3'h3}
    |=> s.q_close == $past(s.q_close))
    else $error("reserved close subcode acted");

  c_step: cover property (s.stb.rfsh_open_step_cmd);
  c_masked: cover property (s.stb.masked_store_cmd ##[1:20] s.wr_v);
  c_read: cover property (s.stb.col_read_cmd ##[1:20] s.oe);
  c_pdn: cover property (s.stb.powerdown_cmd);

endmodule : req_decoder
`default_nettype wire

// ---- design/req_decoder_cfg.svh ----
// Constants of the request packet decoder: field positions, codes, timing,
// register offsets and reset values. Assumes a 40 MHz system clock.
//
// Functional notes
// R01: Two 12-bit request words per link cycle join into one 24-bit packet.
// R02: Assembled 24 bits load a register once per link cycle, then decode.
// R03: Packet taken on two successive link edges; 4-bit format code chooses type.
// R04: Five formats: open, column, masked column, close/refresh, extended.
// R05: Rates derived: 1x packet register, 2x word capture, 8x data beats.
// R06: Delay fields postpone decoded commands by whole link cycles.
// R07: Core command registers load only on a link rising edge; the trim and power-down strobes load at decode instead.
// R08: Controller waits row, close or column cycle time before reloading.
// R09: Row open selects bank and row and marks that bank open.
// R10: Row close precharges the bank so a later open is accepted.
// R11: Controller issues column commands only to an open bank.
// R12: Write captures sixteen 16-bit words, then drives them to the core.
// R13: Read fetches sixteen 16-bit words and sends them on the data bus.
// R14: Open packet: one slip bit, 3-bit bank, 11-bit row.
// R15: Direction bit 0 reads, 1 writes; slip bit delays zero or one cycle.
// R16: Column packets carry 3-bit bank, 6-bit column, 4-bit subword select.
// R17: Masked packet carries 8-bit byte mask applied to the masked store.
// R18: Close/refresh packet holds independent precharge and refresh commands.
// R19: 3-bit close subcode gives precharge and 0..3 cycle delay; 3-bit bank.
// R20: 8-bit refresh field gives bank, delay and row load value.
// R21: Extended packet carries 4-bit maintenance subcode.
// R22: Control registers hold refresh row, power mode and trim state.
// R23: Format 0 nop, 1 column, 2 extended, 3 close/refresh, 01xx open, 1xxx masked.
// R24: Refresh subcodes idle, close, open, open-step, load low, load mid.
// R25: Close subcode 0 idle, 1..3 reserved, 4..7 precharge with delay.
// R26: Maintenance 8 current trim, 9 impedance, a trim end, c power down.
// R27: Reserved subcodes do nothing to banks or refresh row pointer.
`ifndef REQ_DECODER_CFG_SVH
`define REQ_DECODER_CFG_SVH

`define LINK_PERIOD_NS   200
`define CLK_PERIOD_NS    25
`define CLKS_PER_CYCLE   (`LINK_PERIOD_NS / `CLK_PERIOD_NS)
`define BEATS_PER_CYCLE  8
`define CLKS_PER_BEAT    (`CLKS_PER_CYCLE / `BEATS_PER_CYCLE)

`define F_FMT        20
`define F_OPEN_SLIP  19
`define F_OPEN_BNK   16
`define F_OPEN_ROW   0
`define F_DIR        14
`define F_COL_SLIP   13
`define F_COL_BNK    10
`define F_COL        4
`define F_SUB        0
`define F_MASK       14
`define F_CLOSE_SUB  17
`define F_CLOSE_BNK  14
`define F_RFSH_SUB   11
`define F_RFSH_FLD   0
`define F_MAINT      0

`define FMT_NOP      2'h0
`define FMT_COL      2'h1
`define FMT_EXT      2'h2
`define FMT_CLOSE    2'h3
`define FMT_OPEN_TOP 2'h1

`define RF_CLOSE     3'h1
`define RF_OPEN      3'h2
`define RF_STEP      3'h3
`define RF_LOW       3'h4
`define RF_MID       3'h5

`define MX_CUR       4'h8
`define MX_IMP       4'h9
`define MX_END       4'ha
`define MX_PDN       4'hc

`define A_CTRL       8'h00
`define A_ROW        8'h04
`define A_STAT       8'h08
`define C_EN         0
`define C_WAKE       1
`define EN_RST       1'h1

`endif

// ---- design/req_decoder_pkg.sv ----
// Types shared by the request packet decoder and its surroundings.
// Assumes the constants header is compiled alongside.
package req_decoder_pkg;

  typedef enum logic [3:0] {
    DP_IDLE  = 4'b0001,
    DP_FETCH = 4'b0010,
    DP_WRITE = 4'b0100,
    DP_READ  = 4'b1000
  } dp_state_t;

  typedef struct packed {
    logic        v;
    logic [2:0]  kind;
    logic [2:0]  bank;
    logic [11:0] row;
    logic [5:0]  col;
    logic [3:0]  sub;
    logic [7:0]  mask;
  } cmd_t;

  typedef cmd_t [3:0] slot_t;

  typedef struct packed {
    logic [2:0]  bank;
    logic [11:0] row;
  } row_addr_t;

  typedef struct packed {
    logic [2:0] bank;
    logic [5:0] col;
    logic [3:0] sub;
    logic [7:0] mask;
  } col_addr_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic row_open_cmd;
    logic bank_close_cmd;
    logic col_read_cmd;
    logic col_write_cmd;
    logic masked_store_cmd;
    logic rfsh_close_cmd;
    logic rfsh_open_cmd;
    logic rfsh_open_step_cmd;
    logic current_trim_cmd;
    logic impedance_trim_cmd;
    logic trim_end_cmd;
    logic powerdown_cmd;
  } strobe_t;

endpackage : req_decoder_pkg

// ---- sim/link_ctrl_model.sv ----
// Far-side controller model: link clock, request words, write data.
// Assumes the bench calls send just after a system clock edge.
`timescale 1ns/1ps
`default_nettype none
module link_ctrl_model (
  // system clock
  input  wire logic        clock,
  // request and data link
  output logic             master_clock_pos,
  output logic             master_clock_neg,
  output logic [11:0]      request_bus,
  output logic [15:0]      data_bus_in,
  // frames sent so far
  output int               frame
);
  initial begin
    master_clock_pos = 1'b0;
    master_clock_neg = 1'b1;
    request_bus      = 12'h000;
    data_bus_in      = 16'h0000;
    frame            = 0;
  end
  // data moves every beat so a stale word never passes for a fresh one
  always @(posedge clock) begin
    data_bus_in <= data_bus_in * 16'h0005 + 16'h3c2b;
  end
  // ---------------------------------------------
  // one frame, then the link clock stands still
  // ---------------------------------------------
  task automatic send(input logic [23:0] pkt);
    #7;
    request_bus      = pkt[23:12];
    #15;
    frame            = frame + 1;
    master_clock_pos = 1'b1;
    master_clock_neg = 1'b0;
    #85;
    request_bus      = pkt[11:0];
    #15;
    master_clock_pos = 1'b0;
    master_clock_neg = 1'b1;
    #85;
    request_bus      = ~pkt[11:0];
    // twelve system clocks per frame keep link edges off the clock edge
    #93;
  endtask : send
endmodule : link_ctrl_model
`default_nettype wire

// ---- sim/req_decoder_bench.sv ----
// Self-checking bench of the request decoder against a reference model.
// Assumes the design sources and the controller model compile first.
`timescale 1ns/1ps
`default_nettype none
`include "req_decoder_cfg.svh"
module req_decoder_bench;
  import req_decoder_pkg::*;
  logic         clock, rst, data_bus_oe, wr_packet_valid, err;
  logic         master_clock_pos, master_clock_neg;
  logic [11:0]  request_bus, rfsh_row_ptr, ptr;
  logic [15:0]  data_bus_in, data_bus_out;
  apb_req_t     apb_req;
  apb_rsp_t     apb_rsp;
  strobe_t      strobes;
  row_addr_t    open_addr;
  col_addr_t    col_addr;
  logic [2:0]   close_bank, rfsh_target_bnk, last_open;
  logic [255:0] wr_packet, rd_packet, rd_word, exp_w;
  logic [41:0]  addr_now;
  logic [15:0]  hist [0:16383];
  strobe_t      got_s [0:511];
  strobe_t      exp_s [0:511];
  logic [41:0]  exp_a [0:511];
  logic [41:0]  exp_m [0:511];
  logic [31:0]  rdat;
  logic [23:0]  p;
  int           frame, cyc, wr_at, rd_at, bad_count, checked, r;
  int           seed = 45107;

  req_decoder req_decoder_inst (
    .clock(clock), .rst(rst), .master_clock_pos(master_clock_pos),
    .master_clock_neg(master_clock_neg), .request_bus(request_bus),
    .data_bus_in(data_bus_in), .data_bus_out(data_bus_out),
    .data_bus_oe(data_bus_oe), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .strobes(strobes), .open_addr(open_addr), .close_bank(close_bank),
    .col_addr(col_addr), .rfsh_target_bnk(rfsh_target_bnk),
    .rfsh_row_ptr(rfsh_row_ptr), .wr_packet(wr_packet),
    .wr_packet_valid(wr_packet_valid), .rd_packet(rd_packet)
  );
  link_ctrl_model link_ctrl_model_inst (
    .clock(clock), .master_clock_pos(master_clock_pos),
    .master_clock_neg(master_clock_neg), .request_bus(request_bus),
    .data_bus_in(data_bus_in), .frame(frame)
  );

  initial clock = 1'b0;
  always #12.5 clock = ~clock;
  assign addr_now = {open_addr, close_bank, col_addr, rfsh_target_bnk};

  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    do @(posedge clock); while (apb_rsp.pready !== 1'b1);
    rdat = apb_rsp.prdata;
    err  = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge clock);
  endtask : apb

  // ------------------------------------------
  // monitor: strobes, write and read bursts
  // ------------------------------------------
  always @(posedge clock) begin
    cyc = cyc + 1;
    hist[cyc] = data_bus_in;
    for (int k = 0; k < 8; k++) rd_packet[32*k +: 32] <= $random(seed);
    if (|strobes === 1'b1) begin
      got_s[frame] = got_s[frame] | strobes;
      chk(addr_now & exp_m[frame], exp_a[frame]);
    end
    if (strobes.col_write_cmd === 1'b1) wr_at = cyc;
    if (strobes.masked_store_cmd === 1'b1) wr_at = cyc;
    if (wr_packet_valid === 1'b1) begin
      for (int k = 0; k < 16; k++) exp_w[16*k +: 16] = hist[wr_at - 3 + k];
      chk(cyc - wr_at, 16);
      chk(wr_packet, exp_w);
    end
    if (strobes.col_read_cmd === 1'b1) rd_at = cyc;
    if (cyc == rd_at) rd_word = rd_packet;
    if (cyc > rd_at + 1 && cyc < rd_at + 18)
      chk({data_bus_oe, data_bus_out},
          {1'b1, rd_word[16*(cyc-rd_at-2) +: 16]});
    if (cyc == rd_at + 18) chk(data_bus_oe, 1'b0);
    if (cyc == 12000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic add(input int f, input strobe_t s, input logic [41:0] a,
                     input logic [41:0] m);
    exp_s[f] = exp_s[f] | s;
    exp_a[f] = exp_a[f] | a;
    exp_m[f] = exp_m[f] | m;
  endtask : add

  // ------------------------------------------
  // reference model of one packet
  // ------------------------------------------
  task automatic run(input logic [23:0] q, input logic ign);
    int         n;
    strobe_t    s;
    logic [7:0] mk;
    n  = frame + 1;
    s  = '0;
    mk = q[23] ? q[21:14] : 8'hff;
    if (!ign) begin
      casez (q[23:20])
        4'b1???, 4'h1: begin
          s.masked_store_cmd = q[23];
          s.col_write_cmd    = !q[23] && q[14];
          s.col_read_cmd     = !q[23] && !q[14];
          add(n + 1 + q[13], s, {18'h0, q[12:0], mk, 3'h0},
              {18'h0, 21'h1fffff, 3'h0});
        end
        4'b01??: begin
          s.row_open_cmd = 1'b1;
          add(n + 1 + q[19], s, {q[18:16], 1'b0, q[10:0], 27'h0},
              {15'h7fff, 27'h0});
        end
        4'h2: begin
          s.current_trim_cmd   = q[3:0] == 4'h8;
          s.impedance_trim_cmd = q[3:0] == 4'h9;
          s.trim_end_cmd       = q[3:0] == 4'ha;
          s.powerdown_cmd      = q[3:0] == 4'hc;
          add(n, s, 42'h0, 42'h0);
        end
        4'h3: begin
          s.bank_close_cmd = 1'b1;
          if (q[19]) add(n + 1 + q[18:17], s, {15'h0, q[16:14], 24'h0},
                         {15'h0, 3'h7, 24'h0});
          s = '0;
          s.rfsh_close_cmd     = q[13:11] == 3'h1;
          s.rfsh_open_cmd      = q[13:11] == 3'h2 || q[13:11] == 3'h3;
          s.rfsh_open_step_cmd = q[13:11] == 3'h3;
          if (s != '0) add(n + 1 + q[7:6], s, {39'h0, q[2:0]},
                           {39'h0, 3'h7});
          if (q[13:11] == 3'h4) ptr[7:0] = q[7:0];
          if (q[13:11] == 3'h5) ptr[11:8] = q[3:0];
          if (q[13:11] == 3'h3) ptr = ptr + 12'h001;
        end
        default: ;
      endcase
    end
    link_ctrl_model_inst.send(q);
    repeat (4) link_ctrl_model_inst.send(24'h000000);
    for (int f = n; f < n + 5; f++) chk(got_s[f], exp_s[f]);
    chk(rfsh_row_ptr, ptr);
    @(posedge clock);
  endtask : run

  initial begin
    rst = 1'b1;
    apb_req = '0;
    rd_packet = '0;
    ptr = 12'hffe;
    wr_at = -100;
    rd_at = -100;
    last_open = 3'h0;
    for (int i = 0; i < 512; i++) begin
      got_s[i] = '0;
      exp_s[i] = '0;
      exp_a[i] = '0;
      exp_m[i] = '0;
    end
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rdat, i == 0 ? 32'h1 : 32'h0);
    end
    apb(1'b0, 8'h0c, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, `A_ROW, 32'hffe);
    apb(1'b0, `A_ROW, 32'h0);
    chk(rdat, 32'hffe);
    $display("test registers done");
    for (int i = 0; i < 48; i++) begin
      p = 24'($random(seed));
      r = i / 6;
      case (i % 6)
        0: begin
          p[23:22]  = 2'b01;
          last_open = p[18:16];
        end
        1: p[23:20] = 4'h1;
        2: p[23] = 1'b1;
        3: begin
          p[23:20] = 4'h3;
          p[19:17] = 3'(7 - r);
          p[16:14] = last_open ^ 3'h4;
          p[13:11] = 3'(r);
        end
        4: begin
          p[23:20] = 4'h2;
          if (p[3:0] == 4'hc) p[3:0] = 4'hb;
          if (r < 3) p[3:0] = 4'h8 + 4'(r);
        end
        default: p[23:20] = 4'h0;
      endcase
      if (i % 6 == 1 || i % 6 == 2) p[12:10] = last_open;
      run(p, 1'b0);
    end
    $display("test packets done");
    apb(1'b1, `A_CTRL, 32'h0);
    run(24'h512345, 1'b1);
    apb(1'b1, `A_CTRL, 32'h1);
    run(24'h20000c, 1'b0);
    run(24'h512345, 1'b1);
    apb(1'b0, `A_STAT, 32'h0);
    chk(rdat[8], 1'b1);
    apb(1'b1, `A_CTRL, 32'h3);
    apb(1'b0, `A_STAT, 32'h0);
    chk(rdat[8], 1'b0);
    run(24'h512345, 1'b0);
    $display("test power down done");
    end_sim();
  end
endmodule : req_decoder_bench
`default_nettype wire
